// file: hdl/sabi_pkg.sv
// Package for the converter control block: timing constants, states and carrier structs
package sabi_pkg;
   // ********************************************************************
   // Clock and timing
   // ********************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_DELAY_NS = 1000;
   localparam int RESET_DELAY_CYC = (RESET_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LSB_EXTRA_NS = 200;
   localparam int LSB_EXTRA_CYC = (LSB_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BIT_TIME_NS = 2000;
   localparam int BIT_TIME_CYC = BIT_TIME_NS / CLK_PERIOD_NS;
   localparam int SETTLE_NS = 500;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DONE_MAX_NS = 1500;
   localparam int DONE_MAX_CYC = DONE_MAX_NS / CLK_PERIOD_NS;
   localparam int RES_W = 10;
   localparam int CNT_W = 8;
   localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;
   localparam logic [RES_W-1:0] RES_RESET = 10'h000;
   localparam logic [3:0] BIT_TOP = 4'h9;

   // ********************************************************************
   // States and carriers
   // ********************************************************************
   typedef enum logic [1:0] {
      SABI_IDLE = 2'b00,
      SABI_CLEAR = 2'b01,
      SABI_WAIT = 2'b10,
      SABI_CONV = 2'b11
   } sabi_state_e;

   typedef struct packed {
      logic [7:0] upper;
      logic [1:0] lower;
   } sabi_data_s;

   typedef struct packed {
      logic upper_oe;
      logic lower_oe;
   } sabi_oe_s;
endpackage

// file: hdl/sabi_core.sv
// Successive-approximation control, done flag and byte-gated result drivers
`timescale 1ns/1ns
`default_nettype none

// ***********************************************************************
// Summary of operation
// ***********************************************************************
module sabi_core #(
   parameter int BIT_CYC = sabi_pkg::BIT_TIME_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Conversion control
   input wire logic convert,
   input wire logic comp_keep,
   output logic conversion_done_n,
   output logic [sabi_pkg::RES_W-1:0] trial_code,
   // Byte enables
   input wire logic high_byte_oe_n,
   input wire logic low_byte_oe_n,
   // Data pins, three signals each
   output sabi_pkg::sabi_data_s result_out,
   output sabi_pkg::sabi_oe_s result_oe,
   input wire sabi_pkg::sabi_data_s result_in
);
   // ********************************************************************
   // State
   // ********************************************************************
   sabi_pkg::sabi_state_e state_q, state_d;
   logic [sabi_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [3:0] bit_q, bit_d;
   logic [sabi_pkg::RES_W-1:0] sar_q, sar_d;
   logic done_n_q, done_n_d;
   logic conv_q, conv_d;
   logic lsb_q, lsb_d;
   logic [sabi_pkg::CNT_W-1:0] settle_q, settle_d;
   sabi_pkg::sabi_data_s out_q, out_d;
   logic conv_prev_q;
   logic rise, fall;
   logic [sabi_pkg::CNT_W-1:0] clear_age_q, clear_age_d;

   // Bit mask helper for a position
   function automatic logic [sabi_pkg::RES_W-1:0] bit_mask(input logic [3:0] idx);
      bit_mask = sabi_pkg::RES_W'(1) << idx;
   endfunction

   // Edge detect; input taken as synchronous
   assign rise = convert && !conv_prev_q;
   assign fall = !convert && conv_prev_q;

   // ********************************************************************
   // Sequencer
   // ********************************************************************
   // Next-state for clear, wait-for-fall and bit trials
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q;
      bit_d = bit_q;
      sar_d = sar_q;
      done_n_d = done_n_q;
      lsb_d = lsb_q;
      if (rise) begin
         // Clearing restarts on any rise, even mid conversion
         state_d = sabi_pkg::SABI_CLEAR;
         // Longer clear when old LSB set
         cnt_d = sabi_pkg::CNT_W'(sabi_pkg::RESET_DELAY_CYC - 1);
         if (sar_q[0]) begin
            cnt_d = sabi_pkg::CNT_W'(sabi_pkg::RESET_DELAY_CYC + sabi_pkg::LSB_EXTRA_CYC - 1);
         end
         lsb_d = sar_q[0];
      end else begin
         case (state_q)
            sabi_pkg::SABI_IDLE: begin
               state_d = sabi_pkg::SABI_IDLE;
            end
            sabi_pkg::SABI_CLEAR: begin
               if (cnt_q == sabi_pkg::CNT_RESET) begin
                  sar_d = sabi_pkg::RES_RESET;
                  done_n_d = 1'b1;
                  state_d = convert ? sabi_pkg::SABI_WAIT : sabi_pkg::SABI_CONV;
                  bit_d = sabi_pkg::BIT_TOP;
                  cnt_d = sabi_pkg::CNT_W'(BIT_CYC - 1);
                  sar_d = convert ? sabi_pkg::RES_RESET : bit_mask(sabi_pkg::BIT_TOP);
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            sabi_pkg::SABI_WAIT: begin
               if (fall) begin
                  // Conversion starts at falling edge
                  state_d = sabi_pkg::SABI_CONV;
                  sar_d = bit_mask(sabi_pkg::BIT_TOP);
               end
            end
            sabi_pkg::SABI_CONV: begin
               if (cnt_q == sabi_pkg::CNT_RESET) begin
                  // Keep or drop trial bit, then try the next one down
                  if (!comp_keep) begin
                     sar_d = sar_q & ~bit_mask(bit_q);
                  end
                  cnt_d = sabi_pkg::CNT_W'(BIT_CYC - 1);
                  if (bit_q == 4'h0) begin
                     state_d = sabi_pkg::SABI_IDLE;
                     done_n_d = 1'b0;
                  end else begin
                     bit_d = bit_q - 1'b1;
                     sar_d = (comp_keep ? sar_q : sar_q & ~bit_mask(bit_q))
                        | bit_mask(bit_q - 1'b1);
                  end
               end else begin
                  cnt_d = cnt_q - 1'b1;
               end
            end
            default: begin
               state_d = sabi_pkg::SABI_IDLE;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         state_q <= sabi_pkg::SABI_IDLE;
         cnt_q <= sabi_pkg::CNT_RESET;
         bit_q <= sabi_pkg::BIT_TOP;
         sar_q <= sabi_pkg::RES_RESET;
         done_n_q <= 1'b0;
         lsb_q <= 1'b0;
         conv_prev_q <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         bit_q <= bit_d;
         sar_q <= sar_d;
         done_n_q <= done_n_d;
         lsb_q <= lsb_d;
         conv_prev_q <= convert;
      end
   end

   // ********************************************************************
   // Output drivers
   // ********************************************************************
   // Settle counter: final bits reach pins a while after done falls
   always_comb begin
      conv_d = (state_d == sabi_pkg::SABI_CONV) || (state_d == sabi_pkg::SABI_WAIT)
         || (state_d == sabi_pkg::SABI_CLEAR);
      settle_d = settle_q;
      if (conv_d) begin
         settle_d = sabi_pkg::CNT_W'(sabi_pkg::SETTLE_CYC);
      end else if (settle_q != sabi_pkg::CNT_RESET) begin
         settle_d = settle_q - 1'b1;
      end
      // Fixed left-justified placement; partial value shows mid conversion
      out_d = out_q;
      if (conv_d || settle_q == sabi_pkg::CNT_RESET) begin
         out_d.upper = sar_d[9:2];
         out_d.lower = sar_d[1:0];
      end
   end

   // Output registers
   always_ff @(posedge mclk) begin
      if (rst) begin
         conv_q <= 1'b0;
         settle_q <= sabi_pkg::CNT_RESET;
         out_q <= '0;
      end else begin
         conv_q <= conv_d;
         settle_q <= settle_d;
         out_q <= out_d;
      end
   end

   // Enables drive pins directly, even mid conversion
   assign result_oe.upper_oe = !high_byte_oe_n;
   assign result_oe.lower_oe = !low_byte_oe_n;
   assign result_out = out_q;
   assign conversion_done_n = done_n_q;
   assign trial_code = sar_q;

   // ********************************************************************
   // Check helpers
   // ********************************************************************
   // Age of the clear phase; saturates so a stuck clear cannot wrap back
   always_comb begin
      clear_age_d = sabi_pkg::CNT_RESET;
      if (state_d == sabi_pkg::SABI_CLEAR) begin
         if (rise) begin
            clear_age_d = sabi_pkg::CNT_W'(1);
         end else if (clear_age_q != {sabi_pkg::CNT_W{1'b1}}) begin
            clear_age_d = clear_age_q + 1'b1;
         end else begin
            clear_age_d = clear_age_q;
         end
      end
   end

   // Clear age register
   always_ff @(posedge mclk) begin
      if (rst) begin
         clear_age_q <= sabi_pkg::CNT_RESET;
      end else begin
         clear_age_q <= clear_age_d;
      end
   end

   // ********************************************************************
   // Checks
   // ********************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   done_rise_bound_a: assert property (
      clear_age_q <= sabi_pkg::CNT_W'(sabi_pkg::DONE_MAX_CYC))
      else $error("clear phase outlasts its bound");
   clear_done_a: assert property ($past(state_q) == sabi_pkg::SABI_CLEAR
      && state_q != sabi_pkg::SABI_CLEAR |-> done_n_q)
      else $error("done flag low after clear");
   // A strobe shorter than the clear goes straight into the first trial
   clear_on_rise_a: assert property ($rose(done_n_q) |-> sar_q == '0
      || (state_q == sabi_pkg::SABI_CONV && sar_q == bit_mask(sabi_pkg::BIT_TOP)))
      else $error("result not cleared at reset of logic");
   done_fall_a: assert property ($fell(done_n_q) |-> $past(state_q) == sabi_pkg::SABI_CONV)
      else $error("done fell outside a conversion");
   wait_fall_a: assert property (state_q == sabi_pkg::SABI_WAIT && !fall && !rise
      |=> state_q == sabi_pkg::SABI_WAIT)
      else $error("conversion began before strobe fall");
   lsb_delay_a: assert property ($past(state_q) == sabi_pkg::SABI_CLEAR
      && state_q != sabi_pkg::SABI_CLEAR |-> $past(clear_age_q) == (lsb_q
      ? sabi_pkg::CNT_W'(sabi_pkg::RESET_DELAY_CYC + sabi_pkg::LSB_EXTRA_CYC)
      : sabi_pkg::CNT_W'(sabi_pkg::RESET_DELAY_CYC)))
      else $error("clear length ignores old low bit");
   partial_drive_a: assert property (state_q == sabi_pkg::SABI_CONV
      |-> (result_out == sar_q) && (result_oe.upper_oe == !high_byte_oe_n)
      && (result_oe.lower_oe == !low_byte_oe_n))
      else $error("partial value not driven");
   left_just_a: assert property ($fell(settle_q != '0) |=> result_out == sar_q)
      else $error("output placement wrong");
   msb_first_a: assert property (state_q == sabi_pkg::SABI_CONV && $changed(bit_q) && !rise
      && $past(state_q) == sabi_pkg::SABI_CONV
      |-> bit_q == $past(bit_q) - 4'h1)
      else $error("bit order not msb first");
   bit_time_a: assert property ($changed(bit_q) && state_q == sabi_pkg::SABI_CONV && !rise
      |=> $stable(bit_q) [*5])
      else $error("bit trial too short");
   settle_a: assert property ($fell(done_n_q) |-> settle_q != '0)
      else $error("settle window missing");

   conv_done_c: cover property ($fell(done_n_q));
   partial_read_c: cover property (conv_q && !low_byte_oe_n);
   lsb_long_c: cover property (rise && sar_q[0]);
   restart_c: cover property (state_q == sabi_pkg::SABI_CONV && rise);
   short_strobe_c: cover property ($past(state_q) == sabi_pkg::SABI_CLEAR
      && state_q == sabi_pkg::SABI_CONV);
endmodule // sabi_core

`default_nettype wire

// file: dv/sabi_cmp_model.sv
// Comparator model standing in for the analog side of the converter
`timescale 1ns/1ns
`default_nettype none
// ********************
// Comparator model
// ********************
module sabi_cmp_model (
   // Trial code from the approximation register
   input wire logic [sabi_pkg::RES_W-1:0] trial_code,
   // Analog input, given as its ideal code
   input wire logic [sabi_pkg::RES_W-1:0] analog_code,
   // Decision
   output logic comp_keep
);
   // Ideal and noiseless, so the final code must equal the input exactly
   assign comp_keep = (trial_code <= analog_code);
endmodule // sabi_cmp_model
`default_nettype wire

// file: dv/testbench.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
   localparam int BITC = 6;
   localparam int MAX_CONV = 3000; // 30 us at 10 ns
   localparam int SAMPLE_CYC = 1000; // 10 us acquisition
   logic mclk, rst, convert, comp_keep, conversion_done_n;
   logic high_byte_oe_n, low_byte_oe_n;
   logic [9:0] trial_code, analog_code;
   logic [9:0] float_q = 10'h155;
   sabi_pkg::sabi_data_s result_out, bus_in;
   sabi_pkg::sabi_oe_s result_oe;
   int num_errors, num_checks, rise_cyc, conv_cyc, d0, d1;
   // ********************
   // Clock, bus wire, instances
   // ********************
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // Released lines wander, so stale data never passes for valid
   always @(posedge mclk) float_q <= float_q + 10'h001;
   assign bus_in.upper = result_oe.upper_oe ? result_out.upper : ~float_q[9:2];
   assign bus_in.lower = result_oe.lower_oe ? result_out.lower : ~float_q[1:0];
   sabi_core #(.BIT_CYC(BITC)) i_dut (.mclk(mclk), .rst(rst), .convert(convert),
      .comp_keep(comp_keep), .conversion_done_n(conversion_done_n),
      .trial_code(trial_code), .high_byte_oe_n(high_byte_oe_n),
      .low_byte_oe_n(low_byte_oe_n), .result_out(result_out),
      .result_oe(result_oe), .result_in(bus_in));
   sabi_cmp_model i_cmp (.trial_code(trial_code), .analog_code(analog_code),
      .comp_keep(comp_keep));
   // ********************
   // Shared tasks
   // ********************
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Strobe rise, hold past the clear, then fall
   task automatic start_conv(input logic [9:0] code);
      analog_code = code;
      convert = 1'b1;
      rise_cyc = 0;
      do begin
         @(negedge mclk);
         rise_cyc++;
      end while (conversion_done_n !== 1'b1 && rise_cyc < 200);
      chk({9'h000, rise_cyc <= 150}, 10'h001);
      // Hold past the longest clear, so an aborted run is cleared as well
      repeat (160 - rise_cyc) @(negedge mclk);
      chk(result_out, 10'h000);
      chk({9'h000, conversion_done_n}, 10'h001);
      convert = 1'b0;
   endtask
   // Poll the done flag; spent counts cycles already waited since the fall
   task automatic wait_done(input int spent);
      conv_cyc = spent;
      while (conversion_done_n !== 1'b0 && conv_cyc < 3000) begin
         @(negedge mclk);
         conv_cyc++;
      end
      chk({9'h000, conv_cyc >= 10 * BITC && conv_cyc <= 10 * BITC + 4}, 10'h001);
   endtask
   // Settle first, then read whole word and each byte alone
   task automatic read_result(input logic [9:0] code);
      repeat (60) @(negedge mclk);
      high_byte_oe_n = 1'b0;
      low_byte_oe_n = 1'b0;
      @(negedge mclk);
      chk({8'h00, result_oe}, 10'h003);
      chk(bus_in, code);
      low_byte_oe_n = 1'b1;
      @(negedge mclk);
      chk({8'h00, result_oe}, 10'h002);
      chk({2'b00, bus_in.upper}, {2'b00, code[9:2]});
      high_byte_oe_n = 1'b1;
      low_byte_oe_n = 1'b0;
      @(negedge mclk);
      chk({8'h00, result_oe}, 10'h001);
      chk({8'h00, bus_in.lower}, {8'h00, code[1:0]});
      low_byte_oe_n = 1'b1;
      repeat (SAMPLE_CYC) @(negedge mclk);
   endtask
   // ********************
   // Scenarios
   // ********************
   // Extreme and alternating codes; clear is longer after an LSB of one
   task automatic t_codes;
      logic [9:0] codes [4] = '{10'h3FF, 10'h000, 10'h2AB, 10'h154};
      for (int i = 0; i < 4; i++) begin
         start_conv(codes[i]);
         if (i == 0) d0 = rise_cyc;
         if (i == 1) d1 = rise_cyc;
         wait_done(0);
         read_result(codes[i]);
      end
      chk({9'h000, d1 > d0}, 10'h001);
   endtask
   // Enable in mid conversion shows the partial code
   task automatic t_partial;
      start_conv(10'h2AB);
      repeat (3 * BITC) @(negedge mclk);
      high_byte_oe_n = 1'b0;
      @(negedge mclk);
      chk({8'h00, result_oe}, 10'h002);
      chk({9'h000, result_out.upper[7]}, 10'h001);
      high_byte_oe_n = 1'b1;
      wait_done(3 * BITC + 1);
      read_result(10'h2AB);
   endtask
   // A new strobe aborts the running conversion
   task automatic t_abort;
      start_conv(10'h0F0);
      repeat (2 * BITC) @(negedge mclk);
      start_conv(10'h30C);
      wait_done(0);
      read_result(10'h30C);
   endtask
   // Host write: base raises the strobe for the minimum width, base plus one does nothing
   task automatic host_wr(input logic odd);
      convert = !odd;
      repeat (50) @(negedge mclk);
      convert = 1'b0;
   endtask
   // Host read: base gives the high byte, base plus one the low pair on top
   task automatic host_rd(input logic odd, output logic [7:0] d);
      high_byte_oe_n = odd;
      low_byte_oe_n = !odd;
      @(negedge mclk);
      d = odd ? {bus_in.lower, float_q[5:0]} & 8'hC0 : bus_in.upper;
      high_byte_oe_n = 1'b1;
      low_byte_oe_n = 1'b1;
      @(negedge mclk);
   endtask
   // Byte-bus host that never looks at the done flag; short strobe path
   task automatic t_blind;
      logic [7:0] hi, lo;
      analog_code = 10'h2C7;
      host_wr(1'b0);
      host_wr(1'b1);
      repeat (MAX_CONV) @(negedge mclk);
      host_rd(1'b0, hi);
      host_rd(1'b1, lo);
      chk({hi, lo[7:6]}, 10'h2C7);
   endtask
   // Strobe cleared by the done flag's rise, as a stretched write would do
   task automatic t_stretch;
      int exp_cyc;
      exp_cyc = sabi_pkg::RESET_DELAY_CYC + sabi_pkg::LSB_EXTRA_CYC + 1;
      analog_code = 10'h0A5;
      convert = 1'b1;
      rise_cyc = 0;
      do begin
         @(negedge mclk);
         rise_cyc++;
      end while (conversion_done_n !== 1'b1 && rise_cyc < 200);
      convert = 1'b0;
      chk({9'h000, rise_cyc == exp_cyc}, 10'h001);
      wait_done(0);
      read_result(10'h0A5);
   endtask
   // ********************
   // Run control
   // ********************
   task automatic summarize;
      if (num_errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      convert = 1'b0;
      high_byte_oe_n = 1'b1;
      low_byte_oe_n = 1'b1;
      analog_code = 10'h000;
      num_errors = 0;
      num_checks = 0;
      repeat (20) @(negedge mclk);
      rst = 1'b0;
      @(negedge mclk);
      t_codes();
      t_partial();
      t_abort();
      t_blind();
      t_stretch();
      summarize();
   end
   // About 12,500 cycles expected; cut off far beyond
   initial begin
      #400000;
      num_errors++;
      summarize();
   end
endmodule // testbench
`default_nettype wire
